// ==== hrb_report_bank.sv ====
// shared HID report byte bank between USB host and external microcontroller
`include "hrb_regs.svh"
module hrb_report_bank (
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    input  wire logic        CE,
    input  wire logic        HOST_OUT_WR,
    input  wire logic [31:0] HOST_OUT_DATA,
    input  wire logic        HOST_IN_RD,
    output logic      [31:0] HOST_IN_DATA,
    output logic             HOST_IRQ,
    input  wire logic        MCU_WR,
    input  wire logic        MCU_RD,
    input  wire logic [1:0]  MCU_ADDR,
    input  wire logic [7:0]  MCU_WDATA,
    output logic      [7:0]  MCU_RDATA,
    output logic             MICRO_INTERRUPT_LINE,
    input  wire logic [7:0]  GENERAL_INPUT_PINS,
    output logic      [7:0]  GENERAL_OUTPUT_PINS,
    output logic      [7:0]  GENERAL_OUTPUT_OE,
    input  wire logic        BTN_VOL_UP,
    input  wire logic        BTN_VOL_DOWN,
    input  wire logic        BTN_PLAY_MUTE,
    input  wire logic        BTN_REC_MUTE,
    input  wire logic        SPDIF_CFG_BIT5,
    output logic             BUZZER,
    output logic             SPDIF_VALID,
    output logic      [3:0]  SPDIF_CS_NIBBLE,
    output logic      [7:0]  SPDIF_CATEGORY,
    output hrb_pkg::hrb_rate_t MCU_CLK_SEL,
    output logic             EE_START,
    output logic             EE_WRITE,
    output logic      [5:0]  EE_ADDR,
    output logic      [15:0] EE_WDATA,
    input  wire logic        EE_DONE,
    input  wire logic [15:0] EE_RDATA
);
    // the mode field's top bit switches a report group to the indirect registers
    function automatic logic mirrored(input logic [7:0] byte0);
        mirrored = byte0[`HRB_MODE_HI];
    endfunction : mirrored

    function automatic hrb_pkg::hrb_mode_t mode_of(input logic [7:0] byte0);
        mode_of = hrb_pkg::hrb_mode_t'(byte0[`HRB_MODE_HI:`HRB_MODE_LO]);
    endfunction : mode_of

    // offsets are bank-wide, the serial link only carries their low two bits
    function automatic logic addr_is(input logic [1:0] addr, input logic [2:0] offset);
        addr_is = (addr == offset[1:0]);
    endfunction : addr_is

    logic [3:0]  ir0_hi;
    logic [7:0]  ir1;
    logic [7:0]  ir2;
    logic [7:0]  ir3;
    logic [7:0]  or0;
    logic [7:0]  or1;
    logic [7:0]  or2;
    logic [7:0]  or3;
    logic [1:0]  rate;
    logic [7:0]  ee_low;
    logic [7:0]  ee_high;
    logic [6:0]  ee_cfg;
    logic        ee_pending;
    logic [12:0] pins_sync;
    logic [7:0]  general_input_pins;
    logic [7:0]  gpi_prev;
    logic [3:0]  btn_prev;
    logic        spdif_cfg5;
    logic [7:0]  ee_ctrl_view;
    logic [7:0]  host_view0;
    logic [7:0]  host_view1;
    logic [7:0]  host_view2;
    logic [7:0]  host_view3;
    logic [7:0]  mcu_view;
    logic        host_mirror;
    logic        mcu_mirror;
    logic        host_go;
    logic        mcu_go;
    logic [7:0]  wr_b0;
    logic [7:0]  wr_b1;
    logic [7:0]  wr_b2;
    logic [7:0]  wr_b3;
    logic        in_mirror;
    logic        in_pins;
    logic        host_event;

    hrb_btn_if btn ();

    hrb_sync #(
        .WIDTH (13)
    ) u_sync (
        .clk      (MCLK),
        .rst_n    (RST_N),
        .ce       (CE),
        .async_in ({SPDIF_CFG_BIT5, BTN_REC_MUTE, BTN_PLAY_MUTE, BTN_VOL_DOWN, BTN_VOL_UP,
                    GENERAL_INPUT_PINS}),
        .sync_out (pins_sync)
    );

    assign general_input_pins        = pins_sync[7:0];
    assign btn.level  = pins_sync[11:8];
    assign spdif_cfg5 = pins_sync[12];
    // sticky mute flags are consumed when the host collects the input report
    assign btn.clear  = HOST_IN_RD;

    hrb_button u_button (
        .clk   (MCLK),
        .rst_n (RST_N),
        .ce    (CE),
        .btn   (btn)
    );

    assign wr_b0 = HOST_OUT_DATA[7:0];
    assign wr_b1 = HOST_OUT_DATA[15:8];
    assign wr_b2 = HOST_OUT_DATA[23:16];
    assign wr_b3 = HOST_OUT_DATA[31:24];

    // a whole report is written at once, so its own byte0 decides the mirroring
    assign host_mirror = HOST_OUT_WR && mirrored(wr_b0);
    assign host_go     = host_mirror && wr_b3[`HRB_EE_GO_BIT];
    assign mcu_go      = mcu_mirror && addr_is(MCU_ADDR, `HRB_OFF_IR3) && MCU_WDATA[`HRB_EE_GO_BIT];

    // the microcontroller's stored mode, decoded once for every consumer but the buzzer
    assign in_mirror   = mirrored({ir0_hi, 4'h0});
    assign in_pins     = (mode_of({ir0_hi, 4'h0}) == hrb_pkg::HRB_MODE_PINS);

    // a write to byte0 is judged by its own new mode, any other byte by the stored one
    always_comb begin
        if (!MCU_WR) begin
            mcu_mirror = 1'b0;
        end else if (addr_is(MCU_ADDR, `HRB_OFF_IR0)) begin
            mcu_mirror = mirrored(MCU_WDATA);
        end else begin
            mcu_mirror = in_mirror;
        end
    end

    // input report bytes, written by the microcontroller only
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            ir0_hi <= `HRB_NIB_RST;
            ir1    <= `HRB_BYTE_RST;
            ir2    <= `HRB_BYTE_RST;
            ir3    <= `HRB_BYTE_RST;
        end else if (CE && MCU_WR) begin
            case (MCU_ADDR)
                2'h0:    ir0_hi <= MCU_WDATA[7:4];
                2'h1:    ir1    <= MCU_WDATA;
                2'h2:    ir2    <= MCU_WDATA;
                2'h3:    ir3    <= MCU_WDATA;
                default: ir0_hi <= ir0_hi;
            endcase
        end
    end

    // output report bytes, written by the host's Set_Output_Report
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            or0 <= `HRB_BYTE_RST;
            or1 <= `HRB_BYTE_RST;
            or2 <= `HRB_BYTE_RST;
            or3 <= `HRB_BYTE_RST;
        end else if (CE && HOST_OUT_WR) begin
            or0 <= wr_b0;
            or1 <= wr_b1;
            or2 <= wr_b2;
            or3 <= wr_b3;
        end
    end

    // indirect registers; no arbitration, the host write simply wins a collision
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            rate    <= `HRB_RATE_RST;
            ee_low  <= `HRB_BYTE_RST;
            ee_high <= `HRB_BYTE_RST;
            ee_cfg  <= 7'h00;
        end else if (CE) begin
            if (host_mirror) begin
                rate    <= wr_b0[`HRB_RATE_HI:`HRB_RATE_LO];
                ee_low  <= wr_b1;
                ee_high <= wr_b2;
                ee_cfg  <= wr_b3[6:0];
            end else if (mcu_mirror) begin
                case (MCU_ADDR)
                    2'h0:    rate    <= MCU_WDATA[`HRB_RATE_HI:`HRB_RATE_LO];
                    2'h1:    ee_low  <= MCU_WDATA;
                    2'h2:    ee_high <= MCU_WDATA;
                    2'h3:    ee_cfg  <= MCU_WDATA[6:0];
                    default: rate    <= rate;
                endcase
            end else if (EE_DONE && !ee_cfg[`HRB_EE_WR_BIT]) begin
                ee_low  <= EE_RDATA[7:0];
                ee_high <= EE_RDATA[15:8];
            end
        end
    end

    // go bit self-clears into a pending flag; a new start wins over completion
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            ee_pending <= 1'b0;
            EE_START   <= 1'b0;
        end else if (CE) begin
            EE_START   <= host_go || mcu_go;
            ee_pending <= (host_go || mcu_go) || (ee_pending && !EE_DONE);
        end
    end

    assign ee_ctrl_view = {ee_pending, ee_cfg};
    assign EE_WRITE     = ee_cfg[`HRB_EE_WR_BIT];
    assign EE_ADDR      = ee_cfg[5:0];
    assign EE_WDATA     = {ee_high, ee_low};
    assign MCU_CLK_SEL  = hrb_pkg::hrb_rate_t'(rate);

    // what the host sees in its input report
    always_comb begin
        host_view0 = {ir0_hi[3:2], mirrored(or0) ? rate : ir0_hi[1:0], btn.status};
        if (mirrored(or0)) begin
            host_view1 = ee_low;
        end else if (in_pins) begin
            host_view1 = general_input_pins;
        end else begin
            host_view1 = ir1;
        end
        host_view2 = mirrored(or0) ? ee_high : ir2;
        host_view3 = mirrored(or0) ? ee_ctrl_view : ir3;
    end

    // what the microcontroller sees of the output report
    always_comb begin
        case (MCU_ADDR)
            2'h0:    mcu_view = in_mirror ? {`HRB_MIRROR_OR0_HI, rate, 4'h0} : or0;
            2'h1:    mcu_view = in_mirror ? ee_low : or1;
            2'h2:    mcu_view = in_mirror ? ee_high : or2;
            2'h3:    mcu_view = in_mirror ? ee_ctrl_view : or3;
            default: mcu_view = or0;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            HOST_IN_DATA <= 32'h0000_0000;
            MCU_RDATA    <= `HRB_BYTE_RST;
        end else if (CE) begin
            HOST_IN_DATA <= {host_view3, host_view2, host_view1, host_view0};
            if (MCU_RD) begin
                MCU_RDATA <= mcu_view;
            end
        end
    end

    // interrupt to the MCU: set wins over the clearing read
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            MICRO_INTERRUPT_LINE <= 1'b0;
        end else if (CE) begin
            MICRO_INTERRUPT_LINE <= HOST_OUT_WR || EE_DONE
                                    || (MICRO_INTERRUPT_LINE && !MCU_RD);
        end
    end

    // every cause of a host report interrupt; a button change lets the host resync
    always_comb begin
        host_event = MCU_WR || EE_DONE;
        if (btn_prev != btn.status) begin
            host_event = 1'b1;
        end
        if ((gpi_prev != general_input_pins) && in_pins) begin
            host_event = 1'b1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            gpi_prev <= `HRB_BYTE_RST;
            btn_prev <= `HRB_NIB_RST;
            HOST_IRQ <= 1'b0;
        end else if (CE) begin
            gpi_prev <= general_input_pins;
            btn_prev <= btn.status;
            HOST_IRQ <= host_event;
        end
    end

    // pins hold their last setting while the output group is used otherwise
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            GENERAL_OUTPUT_PINS <= `HRB_BYTE_RST;
            GENERAL_OUTPUT_OE   <= `HRB_BYTE_RST;
        end else if (CE && mode_of(or0) == hrb_pkg::HRB_MODE_PINS) begin
            GENERAL_OUTPUT_PINS <= or1;
            GENERAL_OUTPUT_OE   <= or2;
        end
    end

    // buzzer from either side's bit5 when that side is not mirrored
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            BUZZER <= 1'b0;
        end else if (CE) begin
            BUZZER <= (!mirrored(or0) && or0[`HRB_BUZZ_BIT])
                      || (!ir0_hi[3] && ir0_hi[1]);
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            SPDIF_VALID     <= 1'b0;
            SPDIF_CS_NIBBLE <= `HRB_NIB_RST;
            SPDIF_CATEGORY  <= `HRB_BYTE_RST;
        end else if (CE && !mirrored(or0)) begin
            SPDIF_VALID     <= or0[`HRB_VALID_BIT];
            SPDIF_CS_NIBBLE <= or0[3:0];
            if (!spdif_cfg5) begin
                SPDIF_CATEGORY <= or3;
            end
        end
    end
endmodule : hrb_report_bank

// ==== hrb_regs.svh ====
// register offsets, field positions and reset values of the report bank
`ifndef HRB_REGS_SVH
`define HRB_REGS_SVH

`define HRB_OFF_IR0        3'h0
`define HRB_OFF_IR1        3'h1
`define HRB_OFF_IR2        3'h2
`define HRB_OFF_IR3        3'h3
`define HRB_OFF_OR0        3'h4
`define HRB_OFF_OR1        3'h5
`define HRB_OFF_OR2        3'h6
`define HRB_OFF_OR3        3'h7

`define HRB_MODE_HI        7
`define HRB_MODE_LO        6
`define HRB_BUZZ_BIT       5
`define HRB_VALID_BIT      4
`define HRB_RATE_HI        5
`define HRB_RATE_LO        4
`define HRB_EE_GO_BIT      7
`define HRB_EE_WR_BIT      6
`define HRB_BTN_REC        3
`define HRB_BTN_PLAY       2
`define HRB_BTN_DOWN       1
`define HRB_BTN_UP         0

`define HRB_BYTE_RST       8'h00
`define HRB_NIB_RST        4'h0
`define HRB_RATE_RST       2'h0
`define HRB_MIRROR_OR0_HI  2'h3
`define HRB_SYNC_STAGES    2

`endif

// ==== hrb_pkg.sv ====
// types shared by the report bank modules
package hrb_pkg;
    typedef enum logic [1:0] {
        HRB_MODE_PINS    = 2'h0,
        HRB_MODE_GENERIC = 2'h1,
        HRB_MODE_MIRROR  = 2'h2,
        HRB_MODE_RSVD    = 2'h3
    } hrb_mode_t;

    typedef enum logic [1:0] {
        HRB_RATE_1M5 = 2'h0,
        HRB_RATE_3M  = 2'h1,
        HRB_RATE_6M  = 2'h2,
        HRB_RATE_RSV = 2'h3
    } hrb_rate_t;
endpackage : hrb_pkg

// ==== hrb_btn_if.sv ====
// button levels and sticky press-release flags between the bank and its tracker
interface hrb_btn_if;
    logic [3:0] level;
    logic [3:0] status;
    logic       clear;

    modport owner   (output level, output clear, input status);
    modport tracker (input level, input clear, output status);
endinterface : hrb_btn_if

// ==== hrb_sync.sv ====
// two-flop synchroniser for a vector of asynchronous pins
module hrb_sync #(
    parameter int WIDTH = 13
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage1   <= '0;
            sync_out <= '0;
        end else if (ce) begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : hrb_sync

// ==== hrb_button.sv ====
// button tracker: live levels for volume keys, sticky press-then-release for mute keys
`include "hrb_regs.svh"
module hrb_button (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    hrb_btn_if.tracker btn
);
    logic [1:0] held;
    logic [1:0] flag;
    logic [1:0] release_now;

    // mute keys: index 1 record, index 0 playback
    assign release_now = held & ~btn.level[`HRB_BTN_REC:`HRB_BTN_PLAY];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            held <= 2'h0;
        end else if (ce) begin
            held <= btn.level[`HRB_BTN_REC:`HRB_BTN_PLAY];
        end
    end

    // set wins over the host's clear so a release is never lost
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag <= 2'h0;
        end else if (ce) begin
            flag <= (btn.clear ? 2'h0 : flag) | release_now;
        end
    end

    assign btn.status = {flag, btn.level[`HRB_BTN_DOWN:`HRB_BTN_UP]};
endmodule : hrb_button

// ==== hrb_asserts.sv ====
// port-level assertions for the report bank
module hrb_asserts (
    input wire logic               MCLK,
    input wire logic               RST_N,
    input wire logic               CE,
    input wire logic               HOST_OUT_WR,
    input wire logic        [31:0] HOST_OUT_DATA,
    input wire logic               HOST_IRQ,
    input wire logic               MCU_WR,
    input wire logic               MCU_RD,
    input wire logic        [7:0]  MCU_RDATA,
    input wire logic               MICRO_INTERRUPT_LINE,
    input wire logic        [7:0]  GENERAL_OUTPUT_PINS,
    input wire logic        [7:0]  GENERAL_OUTPUT_OE,
    input wire logic               SPDIF_VALID,
    input wire logic        [3:0]  SPDIF_CS_NIBBLE,
    input wire hrb_pkg::hrb_rate_t MCU_CLK_SEL,
    input wire logic               EE_START,
    input wire logic        [5:0]  EE_ADDR,
    input wire logic        [15:0] EE_WDATA,
    input wire logic               EE_DONE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    sequence host_wr_s; CE && HOST_OUT_WR; endsequence
    // outputs land two edges after the write, so the second edge must run too
    sequence pins_wr_s; host_wr_s ##0 HOST_OUT_DATA[7:6] == 2'h0 ##1 CE; endsequence
    // an eeprom result landing on the same edge is left out, though the host write owns the data bytes
    sequence mirror_wr_s; host_wr_s ##0 HOST_OUT_DATA[7] && !EE_DONE; endsequence
    micro_interrupt_line_set_a:
        assert property (host_wr_s |=> MICRO_INTERRUPT_LINE)
        else $error("mcu interrupt missing after host write");
    micro_interrupt_line_clear_a:
        assert property (CE && MCU_RD && !HOST_OUT_WR && !EE_DONE |=> !MICRO_INTERRUPT_LINE)
        else $error("mcu interrupt not cleared by read");
    ee_done_irq_a:
        assert property (CE && EE_DONE |=> HOST_IRQ && MICRO_INTERRUPT_LINE)
        else $error("eeprom completion not signalled");
    mcu_wr_irq_a:
        assert property (CE && MCU_WR |=> HOST_IRQ)
        else $error("host interrupt missing after mcu write");
    pin_outs_a:
        assert property (pins_wr_s |=> {GENERAL_OUTPUT_OE, GENERAL_OUTPUT_PINS} == $past(HOST_OUT_DATA[23:8], 2)
            && {SPDIF_VALID, SPDIF_CS_NIBBLE} == $past(HOST_OUT_DATA[4:0], 2))
        else $error("pin or status outputs differ from written report");
    ee_start_a:
        assert property (mirror_wr_s ##0 HOST_OUT_DATA[31] |=> EE_START && EE_ADDR == $past(HOST_OUT_DATA[29:24]))
        else $error("eeprom access not started");
    mirror_same_a:
        assert property (mirror_wr_s |=> EE_WDATA == $past(HOST_OUT_DATA[23:8])
            && 2'(MCU_CLK_SEL) == $past(HOST_OUT_DATA[5:4]))
        else $error("mirrored registers not updated with report");
    rdata_hold_a:
        assert property (!(CE && MCU_RD) |=> $stable(MCU_RDATA))
        else $error("mcu read data changed without a read");
endmodule : hrb_asserts

// ==== hrb_ee_model.sv ====
// eeprom engine stand-in: answers a start after a programmable number of cycles
module hrb_ee_model #(
    parameter logic [15:0] READ_WORD = 16'hbeef
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        start,
    input  wire logic [7:0]  delay,
    output logic             done,
    output logic      [15:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] count;
    logic       busy;
    // one access at a time; pending lasts until done
    // word is valid only beside done, elsewhere it churns so stale use shows
    always_ff @(posedge clk) begin
        done  <= 1'h0;
        rdata <= ~rdata;
        if (!rst_n) begin
            busy  <= 1'h0;
            count <= 8'h00;
            rdata <= 16'h0000;
        end else if (start) begin
            busy  <= 1'h1;
            count <= delay;
        end else if (busy && count == 8'h00) begin
            busy  <= 1'h0;
            done  <= 1'h1;
            rdata <= READ_WORD;
        end else if (busy) begin
            count <= count - 8'h01;
        end
    end
endmodule : hrb_ee_model

// ==== tb_top.sv ====
// self-checking bench for the report bank
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        MCLK, RST_N, CE, HOST_OUT_WR, HOST_IN_RD, MCU_WR, MCU_RD, SPDIF_CFG_BIT5;
    logic        BTN_VOL_UP, BTN_VOL_DOWN, BTN_PLAY_MUTE, BTN_REC_MUTE;
    logic [31:0] HOST_OUT_DATA, HOST_IN_DATA;
    logic [1:0]  MCU_ADDR;
    logic [7:0]  MCU_WDATA, GENERAL_INPUT_PINS, ee_dly, MCU_RDATA, GENERAL_OUTPUT_PINS, GENERAL_OUTPUT_OE;
    logic [7:0]  SPDIF_CATEGORY;
    logic        HOST_IRQ, MICRO_INTERRUPT_LINE, BUZZER, SPDIF_VALID, EE_START, EE_WRITE, EE_DONE;
    logic [3:0]  SPDIF_CS_NIBBLE;
    logic [5:0]  EE_ADDR;
    logic [15:0] EE_WDATA, EE_RDATA;
    hrb_pkg::hrb_rate_t MCU_CLK_SEL;
    int          errors = 0, n_compared = 0, n_irq = 0, k;
    wire  [31:0] outs = {SPDIF_CATEGORY, GENERAL_OUTPUT_OE, GENERAL_OUTPUT_PINS, 2'h0, BUZZER, SPDIF_VALID,
                         SPDIF_CS_NIBBLE};
    wire  [31:0] ee_outs = {7'h0, EE_WRITE, 2'h0, EE_ADDR, EE_WDATA};

    hrb_report_bank DUT (
        .MCLK, .RST_N, .CE, .HOST_OUT_WR, .HOST_OUT_DATA, .HOST_IN_RD, .HOST_IN_DATA, .HOST_IRQ,
        .MCU_WR, .MCU_RD, .MCU_ADDR, .MCU_WDATA, .MCU_RDATA, .MICRO_INTERRUPT_LINE,
        .GENERAL_INPUT_PINS, .GENERAL_OUTPUT_PINS, .GENERAL_OUTPUT_OE, .BTN_VOL_UP, .BTN_VOL_DOWN,
        .BTN_PLAY_MUTE, .BTN_REC_MUTE, .SPDIF_CFG_BIT5, .BUZZER, .SPDIF_VALID, .SPDIF_CS_NIBBLE,
        .SPDIF_CATEGORY, .MCU_CLK_SEL, .EE_START, .EE_WRITE, .EE_ADDR, .EE_WDATA, .EE_DONE, .EE_RDATA
    );
    hrb_ee_model u_ee (.clk(MCLK), .rst_n(RST_N), .start(EE_START), .delay(ee_dly), .done(EE_DONE),
                       .rdata(EE_RDATA));

    initial begin
        MCLK = 1'h0;
        forever #20 MCLK = ~MCLK;
    end
    always @(posedge MCLK) if (HOST_IRQ === 1'h1) n_irq++;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    // settle on the falling edge so no check races the launching edge
    task automatic wait_n(input int n);
        repeat (n) @(posedge MCLK);
        @(negedge MCLK);
    endtask : wait_n
    task automatic host_wr(input logic [31:0] d);
        @(posedge MCLK);
        HOST_OUT_DATA <= d;
        HOST_OUT_WR   <= 1'h1;
        @(posedge MCLK);
        HOST_OUT_WR   <= 1'h0;
    endtask : host_wr
    task automatic mcu_wr(input logic [1:0] a, input logic [7:0] d); // never beside a host write
        @(posedge MCLK);
        MCU_ADDR  <= a;
        MCU_WDATA <= d;
        MCU_WR    <= 1'h1;
        @(posedge MCLK);
        MCU_WR    <= 1'h0;
    endtask : mcu_wr
    task automatic mcu_rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge MCLK);
        MCU_ADDR <= a;
        MCU_RD   <= 1'h1;
        @(posedge MCLK);
        MCU_RD   <= 1'h0;
        @(negedge MCLK);
        chk("mcu read", 32'(exp), 32'(MCU_RDATA));
    endtask : mcu_rd
    task automatic wait_done;
        int i;
        for (i = 0; i < 64 && EE_DONE !== 1'h1; i++) @(negedge MCLK);
        if (i == 64) begin
            errors++;
            test_done();
        end
    endtask : wait_done

    initial begin
        {HOST_OUT_WR, HOST_IN_RD, MCU_WR, MCU_RD, HOST_OUT_DATA, MCU_ADDR, MCU_WDATA, RST_N} = '0;
        {BTN_VOL_UP, BTN_VOL_DOWN, BTN_PLAY_MUTE, BTN_REC_MUTE, SPDIF_CFG_BIT5, GENERAL_INPUT_PINS} = '0;
        CE = 1'h1;
        ee_dly = 8'h14;
        repeat (12) @(posedge MCLK);
        RST_N <= 1'h1;
        wait_n(1);
        chk("host in reset", 32'h0, HOST_IN_DATA);
        chk("outputs reset", 32'h0, outs);
        for (int a = 0; a < 4; a++) mcu_rd(2'(a), 8'h00);
        host_wr(32'h5ac3_963b);
        wait_n(2);
        chk("mode0 outputs", 32'h5ac3_963b, outs);
        chk("mcu int set", 32'h1, 32'(MICRO_INTERRUPT_LINE));
        for (int a = 0; a < 4; a++) mcu_rd(2'(a), 8'(32'h5ac3_963b >> (8 * a)));
        chk("mcu int clear", 32'h0, 32'(MICRO_INTERRUPT_LINE));
        @(posedge MCLK);
        SPDIF_CFG_BIT5 <= 1'h1;
        wait_n(4);
        host_wr(32'h11c3_963b);
        wait_n(2);
        chk("category held", 32'h5ac3_963b, outs);
        @(posedge MCLK);
        SPDIF_CFG_BIT5 <= 1'h0;
        wait_n(4);
        host_wr(32'h2211_007f);
        wait_n(2);
        chk("generic outputs", 32'h22c3_963f, outs);
        $display("host output report test done");
        host_wr(32'h0000_0040);
        mcu_wr(2'h0, 8'h7f);
        mcu_wr(2'h1, 8'ha1);
        mcu_wr(2'h2, 8'hb2);
        mcu_wr(2'h3, 8'hc3);
        wait_n(2);
        chk("host in generic", 32'hc3b2_a170, HOST_IN_DATA);
        chk("mcu buzzer", 32'h00c3_9620, outs);
        mcu_wr(2'h0, 8'h00);
        @(posedge MCLK);
        GENERAL_INPUT_PINS <= 8'ha5;
        wait_n(6);
        chk("host in pins", 32'hc3b2_a500, HOST_IN_DATA);
        k = n_irq;
        @(posedge MCLK);
        GENERAL_INPUT_PINS <= 8'h5a;
        wait_n(6);
        chk("pin change irq", 32'h1, 32'(n_irq - k));
        $display("mcu input report test done");
        @(posedge MCLK);
        {BTN_VOL_DOWN, BTN_PLAY_MUTE, BTN_REC_MUTE} <= 3'h7;
        wait_n(6);
        chk("buttons held", 32'h2, 32'(HOST_IN_DATA[3:0]));
        @(posedge MCLK);
        {BTN_VOL_UP, BTN_VOL_DOWN, BTN_PLAY_MUTE, BTN_REC_MUTE} <= 4'h8;
        wait_n(6);
        chk("buttons released", 32'hd, 32'(HOST_IN_DATA[3:0]));
        @(posedge MCLK);
        HOST_IN_RD <= 1'h1;
        @(posedge MCLK);
        HOST_IN_RD <= 1'h0;
        wait_n(2);
        chk("mute flags cleared", 32'h1, 32'(HOST_IN_DATA[3:0]));
        $display("button test done");
        host_wr(32'h8512_3490);
        wait_n(2);
        chk("clock rate", 32'h1, 32'(MCU_CLK_SEL));
        chk("eeprom read request", 32'h0005_1234, ee_outs);
        chk("pending flag", 32'h1, 32'(HOST_IN_DATA[31]));
        mcu_rd(2'h0, 8'h90);
        wait_done();
        wait_n(1);
        chk("mcu int on done", 32'h1, 32'(MICRO_INTERRUPT_LINE));
        wait_n(1);
        chk("eeprom read result", 32'h0005_beef, 32'(HOST_IN_DATA[31:8]));
        @(posedge MCLK);
        ee_dly <= 8'h00;
        host_wr(32'hc7ab_cd90);
        wait_n(1);
        chk("eeprom write request", 32'h0107_abcd, ee_outs);
        wait_done();
        wait_n(2);
        chk("eeprom write done", 32'h47, 32'(HOST_IN_DATA[31:24]));
        $display("eeprom test done");
        mcu_wr(2'h0, 8'ha0);
        mcu_wr(2'h1, 8'h5a);
        mcu_rd(2'h0, 8'he0);
        mcu_rd(2'h1, 8'h5a);
        chk("mcu clock rate", 32'h2, 32'(MCU_CLK_SEL));
        chk("mirror buzzer", 32'h00c3_9600, outs);
        $display("mcu mirror test done");
        test_done();
    end
endmodule : tb_top

bind hrb_report_bank hrb_asserts u_chk (
    .MCLK, .RST_N, .CE, .HOST_OUT_WR, .HOST_OUT_DATA, .HOST_IRQ, .MCU_WR, .MCU_RD, .MCU_RDATA,
    .MICRO_INTERRUPT_LINE, .GENERAL_OUTPUT_PINS, .GENERAL_OUTPUT_OE, .SPDIF_VALID, .SPDIF_CS_NIBBLE,
    .MCU_CLK_SEL, .EE_START, .EE_ADDR, .EE_WDATA, .EE_DONE
);
